// File: core/adcc_top.sv
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "adcc_map.svh"
// Contract
// - Any status/control write aborts and restarts conversion with new settings
// - Interrupt off: done flag read-only, set each single, first continuous
// - Done flag clears on status/control write or result read
// - Interrupt on: done flag is software read/write; reset clears it
// - Interrupt on: request per conversion, cleared by result read or write
// - Continuous bit keeps converting and updating; clear means one conversion
// - Five-bit channel field; codes 0 to 7 pick port B inputs
// - 11101 high reference, 11110 low reference, 11011 reserved test
// - All channel bits one powers the converter off
// - Left format: high holds eight MSBs, low two LSBs, rest zero
// - Right format: high holds two MSBs, low eight LSBs
// - Signed left format: as left but bit nine inverted
// - High read freezes low until low read; results meanwhile discarded
// - Truncation: low holds eight MSBs, high reads zero, no interlock
// - Prescaler divides by 1, 2, 4, 8; top bit set gives 16
// - Input clock select: one bus clock, zero crystal; reset crystal
// - Format codes 00 trunc, 01 right, 10 left, 11 signed; reset right
// - Conversion takes sixteen to seventeen converter clocks after start
// - Continuous results overwrite unread ones unless interlock holds
module adcc_top
  import adcc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic crystal_clock,
  input wire logic [9:0] conv_result,
  output logic conv_start,
  output logic conv_clk_en,
  output logic [4:0] conv_channel,
  output logic conv_power_off,
  output logic conv_irq
);

  // Bus side state
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic acc;
  logic rd_hi;
  logic rd_lo;
  logic rd_res;
  logic wr_sc;
  logic wr_ck;
  logic [7:0] rd_mux;

  // Control registers
  logic flag_r;
  logic irq_en_r;
  logic cont_r;
  logic [4:0] chan_r;
  logic [2:0] div_r;
  logic iclk_r;
  adcc_just_e mode_r;

  // Converter clock path
  logic xs1_r;
  logic xs2_r;
  logic xs3_r;
  logic in_en;
  logic [3:0] div_cnt_r;
  logic [3:0] div_mask;
  logic tick;

  // Conversion sequencing
  adcc_state_e st_r;
  logic [4:0] cyc_r;
  logic done_evt;
  logic start_r;
  logic first_r;
  logic lock_r;
  logic irq_r;
  logic [9:0] res_r;
  logic pwr_off;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // Address phase decode; hsize ignored, word access assumed
  // Byte or halfword accesses still act on the whole register
  // Read side effects fire here, so flag, request and lock react at once
  assign acc = hsel && htrans[1] && hready;
  assign rd_hi = acc && !hwrite && (haddr[7:0] == `ADCC_OFF_RH);
  assign rd_lo = acc && !hwrite && (haddr[7:0] == `ADCC_OFF_RL);
  assign rd_res = rd_hi || rd_lo;

  // Writes act in the data phase, when hwdata is valid
  assign wr_sc = wr_pend_r && (wr_addr_r == `ADCC_OFF_SC);
  assign wr_ck = wr_pend_r && (wr_addr_r == `ADCC_OFF_CK);

  // Capture write address phase
  // Address is held for the data phase; hwdata arrives one cycle later
  // A read in that data phase to the same register still sees the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= acc && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Read data, per justification format
  always_comb begin
    rd_mux = 8'h00; // Unmapped reads return zero
    unique case (haddr[7:0])
      `ADCC_OFF_SC: rd_mux = {flag_r, irq_en_r, cont_r, chan_r};
      `ADCC_OFF_RH: begin
        unique case (mode_r)
          ADCC_TRUNC: rd_mux = 8'h00;
          ADCC_RIGHT: rd_mux = {6'h00, res_r[9:8]};
          ADCC_LEFT: rd_mux = res_r[9:2];
          ADCC_SIGNED: rd_mux = {~res_r[9], res_r[8:2]};
        endcase
      end
      `ADCC_OFF_RL: begin
        unique case (mode_r)
          ADCC_TRUNC: rd_mux = res_r[9:2];
          ADCC_RIGHT: rd_mux = res_r[7:0];
          ADCC_LEFT: rd_mux = {res_r[1:0], 6'h00};
          ADCC_SIGNED: rd_mux = {res_r[1:0], 6'h00};
        endcase
      end
      `ADCC_OFF_CK: rd_mux = {div_r, iclk_r, mode_r, 2'b00};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata_r <= {24'h00_0000, rd_mux};
    end
  end

  // Status/control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_r <= 1'b0;
      cont_r <= 1'b0;
      chan_r <= `ADCC_RST_CH;
    end else if (wr_sc) begin
      irq_en_r <= hwdata[`ADCC_SC_IEN];
      cont_r <= hwdata[`ADCC_SC_CONT];
      chan_r <= hwdata[`ADCC_SC_CH_HI:`ADCC_SC_CH_LO];
    end
  end

  // Clock/format fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= `ADCC_RST_DIV;
      iclk_r <= 1'b0;
      mode_r <= adcc_just_e'(`ADCC_RST_MODE);
    end else if (wr_ck) begin
      div_r <= hwdata[`ADCC_CK_DIV_HI:`ADCC_CK_DIV_LO];
      iclk_r <= hwdata[`ADCC_CK_ICLK];
      mode_r <= adcc_just_e'(hwdata[`ADCC_CK_MODE_HI:`ADCC_CK_MODE_LO]);
    end
  end

  // Crystal clock crosses in by two flops, then edge detect
  // Third flop only feeds the edge detector, never the metastable first stage
  // Crystal must stay well below half the bus clock or edges are lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
    end else begin
      xs1_r <= crystal_clock;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
    end
  end

  // Input clock: bus clock every cycle, or crystal rising edges
  assign in_en = iclk_r ? 1'b1 : (xs2_r && !xs3_r);

  // Divide mask; any code with top bit set divides by 16
  always_comb begin
    unique case (div_r)
      3'h0: div_mask = 4'h0;
      3'h1: div_mask = 4'h1;
      3'h2: div_mask = 4'h3;
      3'h3: div_mask = 4'h7;
      default: div_mask = 4'hf;
    endcase
  end

  // Free-running prescaler over input clock enables
  // Not reset on a divide change, so the first tick after one may come early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_r <= 4'h0;
    end else if (in_en) begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  // Converter clock enable pulse
  assign tick = in_en && ((div_cnt_r & div_mask) == div_mask);
  assign conv_clk_en = tick && !pwr_off;

  // Power off takes precedence over any conversion
  assign pwr_off = (chan_r == `ADCC_CH_OFF);
  assign conv_power_off = pwr_off;
  // Reference and reserved codes pass straight to the multiplexer
  assign conv_channel = chan_r;

  // Last converter clock of a running conversion
  assign done_evt = (st_r == ADCC_RUN) && tick && (cyc_r == `ADCC_CONV_CYC - 5'h1);

  // Conversion sequencer; SYNC absorbs the partial first cycle
  // A write selecting power off parks it, so no run outlives the power down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ADCC_IDLE;
      cyc_r <= 5'h00;
    end else if (wr_sc) begin
      cyc_r <= 5'h00;
      if (hwdata[`ADCC_SC_CH_HI:`ADCC_SC_CH_LO] == `ADCC_CH_OFF) begin
        st_r <= ADCC_IDLE;
      end else begin
        st_r <= ADCC_SYNC;
      end
    end else begin
      unique case (st_r)
        ADCC_IDLE: begin
          cyc_r <= 5'h00;
        end
        ADCC_SYNC: begin
          if (tick) begin
            st_r <= ADCC_RUN;
            cyc_r <= 5'h00;
          end
        end
        ADCC_RUN: begin
          if (done_evt) begin
            cyc_r <= 5'h00;
            st_r <= cont_r ? ADCC_RUN : ADCC_IDLE;
          end else if (tick) begin
            cyc_r <= cyc_r + 5'h01;
          end
        end
        default: begin
          st_r <= ADCC_IDLE;
          cyc_r <= 5'h00;
        end
      endcase
    end
  end

  // One-cycle start pulse to the core at each conversion start
  // Held back on a control write so an aborted run never starts twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= 1'b0;
    end else begin
      start_r <= !wr_sc && (((st_r == ADCC_SYNC) && tick) || (done_evt && cont_r));
    end
  end
  assign conv_start = start_r;

  // Interlock: high read freezes low until low read
  // Also dropped in truncation so a format change cannot leave it stuck
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_r <= 1'b0;
    end else if (rd_lo || mode_r == ADCC_TRUNC) begin
      lock_r <= 1'b0;
    end else if (rd_hi) begin
      lock_r <= 1'b1;
    end
  end

  // Result capture; overwrites unread data unless frozen
  // Discarded results still raise flag and request; only the data is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_r <= 10'h000;
    end else if (done_evt && !lock_r) begin
      res_r <= conv_result;
    end
  end

  // First completion since the last control write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_r <= 1'b0;
    end else if (wr_sc) begin
      first_r <= 1'b0;
    end else if (done_evt) begin
      first_r <= 1'b1;
    end
  end

  // Done flag; hardware set beats any clear in the same cycle
  // Write clear follows the written enable, so leaving interrupt mode drops it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= 1'b0;
    end else if (done_evt && !irq_en_r && (!cont_r || !first_r)) begin
      flag_r <= 1'b1;
    end else if (wr_sc && hwdata[`ADCC_SC_IEN]) begin
      flag_r <= hwdata[`ADCC_SC_FLAG];
    end else if (wr_sc || (rd_res && !irq_en_r)) begin
      flag_r <= 1'b0;
    end
  end

  // Interrupt request; completion wins over a same-cycle result read clear
  // A control write aborts, so it beats a completion in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else if (done_evt && irq_en_r && !wr_sc) begin
      irq_r <= 1'b1;
    end else if (wr_sc || rd_res) begin
      irq_r <= 1'b0;
    end
  end
  assign conv_irq = irq_r;

endmodule : adcc_top

// File: core/adcc_map.svh
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// Register byte offsets (low address byte)
`define ADCC_OFF_SC 8'h00
`define ADCC_OFF_RH 8'h04
`define ADCC_OFF_RL 8'h08
`define ADCC_OFF_CK 8'h0c

// Status/control fields
`define ADCC_SC_FLAG 7
`define ADCC_SC_IEN 6
`define ADCC_SC_CONT 5
`define ADCC_SC_CH_HI 4
`define ADCC_SC_CH_LO 0

// Clock/format fields
`define ADCC_CK_DIV_HI 7
`define ADCC_CK_DIV_LO 5
`define ADCC_CK_ICLK 4
`define ADCC_CK_MODE_HI 3
`define ADCC_CK_MODE_LO 2

// Reset values
`define ADCC_RST_CH 5'h1f
`define ADCC_RST_DIV 3'h0
`define ADCC_RST_MODE 2'h1

// Channel codes
`define ADCC_CH_REFH 5'h1d
`define ADCC_CH_REFL 5'h1e
`define ADCC_CH_OFF 5'h1f

// Converter clock cycles per conversion after alignment
`define ADCC_CONV_CYC 5'h10

`endif

// File: core/adcc_pkg.sv
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_SYNC = 2'b01,
    ADCC_RUN = 2'b10
  } adcc_state_e;

  typedef enum logic [1:0] {
    ADCC_TRUNC = 2'b00,
    ADCC_RIGHT = 2'b01,
    ADCC_LEFT = 2'b10,
    ADCC_SIGNED = 2'b11
  } adcc_just_e;

endpackage : adcc_pkg

// File: sim/adcc_top_asserts.sv
`timescale 1ns/1ps
module adcc_top_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic conv_clk_en,
  input wire logic [4:0] conv_channel,
  input wire logic conv_power_off,
  input wire logic conv_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Any taken transfer; the data phase follows one cycle later
  logic acc;
  assign acc = hsel && htrans[1] && hreadyout;
  sequence s_wr_sc;
    acc && hwrite && haddr[7:0] == 8'h00;
  endsequence
  sequence s_rd_res;
    acc && !hwrite && (haddr[7:0] == 8'h04 || haddr[7:0] == 8'h08);
  endsequence
  property p_chan; s_wr_sc |-> ##2 conv_channel == $past(hwdata[4:0]); endproperty
  property p_wclr; s_wr_sc |-> ##2 !conv_irq; endproperty
  // A tick in the same cycle may complete a conversion and set it again
  property p_rclr; s_rd_res ##0 !conv_clk_en |=> !conv_irq; endproperty
  property p_hold; conv_irq && !acc && !$past(acc) |=> conv_irq; endproperty
  property p_tick; $rose(conv_irq) |-> $past(conv_clk_en); endproperty
  property p_off; conv_power_off == (conv_channel == 5'h1f); endproperty
  property p_quiet; conv_power_off |-> !conv_clk_en; endproperty
  property p_hi; hrdata[31:8] == 24'h0; endproperty
  a_chan: assert property (p_chan) else $error("channel not loaded");
  a_wclr: assert property (p_wclr) else $error("irq kept on write");
  a_rclr: assert property (p_rclr) else $error("irq kept on read");
  a_hold: assert property (p_hold) else $error("irq dropped alone");
  a_tick: assert property (p_tick) else $error("irq off tick");
  a_off: assert property (p_off) else $error("power map");
  a_quiet: assert property (p_quiet) else $error("ticks while off");
  a_hi: assert property (p_hi) else $error("upper bits set");
endmodule : adcc_top_chk
bind adcc_top adcc_top_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .conv_clk_en(conv_clk_en), .conv_channel(conv_channel),
  .conv_power_off(conv_power_off), .conv_irq(conv_irq));

// File: sim/adcc_core_model.sv
`timescale 1ns/1ps
module adcc_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [4:0] channel,
  input wire logic power_off,
  output logic [9:0] result
);
  logic [9:0] seq_r;
  logic [9:0] held_r;
  // Sample at each start; a running count makes every result differ, except the fixed 3ff/000 of reference channels 1d/1e
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= 10'h000;
      held_r <= 10'h155;
    end else if (start) begin
      seq_r <= seq_r + 10'h001;
      if (channel == 5'h1d) held_r <= 10'h3ff;
      else if (channel == 5'h1e) held_r <= 10'h000;
      else held_r <= {channel, 5'h00} + seq_r;
    end else if (power_off) begin
      held_r <= ~held_r; // Unpowered core gives garbage
    end
  end
  assign result = held_r;
endmodule : adcc_core_model

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, crystal_clock = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, conv_start, conv_clk_en, conv_power_off, conv_irq;
  logic [4:0] conv_channel;
  logic [9:0] conv_result;
  int error_cnt = 0, num_checks = 0;
  always #50 hclk = ~hclk;
  // Off-grid period so crystal edges meet bus edges only every 17650 ns, 1.4 MHz
  always #353 crystal_clock = ~crystal_clock;
  adcc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .crystal_clock,
    .conv_result, .conv_start, .conv_clk_en, .conv_channel, .conv_power_off, .conv_irq);
  adcc_core_model i_core (.clk(hclk), .rst_n(hresetn), .start(conv_start),
    .channel(conv_channel), .power_off(conv_power_off), .result(conv_result));
  task automatic finish_test;
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Bounded edge wait on a flag; a hang ends the run
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    do begin @(posedge hclk); n++; end while (s !== 1'b1 && n < 400);
    if (n >= 400) begin error_cnt++; finish_test(); end
  endtask : wait_hi
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    int n;
    hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
    wait_hi(hreadyout, n);
    hsel <= 0; htrans <= 2'b00; hwdata <= {24'h0, d};
    wait_hi(hreadyout, n);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask : rd_chk
  // No starts may appear over a span of conversions
  task automatic quiet;
    logic [7:0] k;
    k = 0;
    repeat (40) begin @(posedge hclk); k += {7'h0, conv_start}; end
    chk(k, 0);
  endtask : quiet
  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
    case (m)
      2'b00: fmt = {8'h00, r[9:2]};
      2'b01: fmt = {6'h00, r};
      2'b10: fmt = {r, 6'h00};
      default: fmt = {~r[9], r[8:0], 6'h00};
    endcase
  endfunction : fmt
  task automatic t_reset;
    rd_chk(8'h00, 8'h1f);
    rd_chk(8'h0c, 8'h04);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h10, 8'h00);
    chk(hresp, 0);
    chk(conv_power_off, 1);
  endtask : t_reset
  // Tick spacing for every divide code, then the crystal source
  task automatic t_clock;
    int n;
    wr(8'h00, 8'h00); // Warm-up conversion after power-on
    for (int d = 0; d < 8; d++) begin
      wr(8'h0c, {d[2:0], 5'h14});
      wait_hi(conv_clk_en, n);
      wait_hi(conv_clk_en, n);
      chk(n, d > 3 ? 16 : 1 << d);
    end
    wr(8'h0c, 8'h04);
    wait_hi(conv_clk_en, n);
    wait_hi(conv_clk_en, n);
    chk(n inside {[7:8]}, 1);
  endtask : t_clock
  task automatic t_flag;
    logic [31:0] q;
    int k;
    wr(8'h0c, 8'h14);
    wr(8'h00, 8'h02);
    k = 0;
    do begin xfer(1'b0, 8'h00, 8'h00, q); k++; end while (q[7] !== 1'b1 && k < 40);
    chk(q, 32'h82);
    quiet();
    xfer(1'b0, 8'h08, 8'h00, q);
    rd_chk(8'h00, 8'h02);
    // Continuous, interrupt off: flag only after the first result
    wr(8'h00, 8'h22);
    k = 0;
    do begin xfer(1'b0, 8'h00, 8'h00, q); k++; end while (q[7] !== 1'b1 && k < 40);
    chk(q, 32'ha2);
    xfer(1'b0, 8'h08, 8'h00, q);
    repeat (40) @(posedge hclk);
    rd_chk(8'h00, 8'h22);
    wr(8'h00, 8'hc2);
    rd_chk(8'h00, 8'hc2);
    wr(8'h00, 8'h02);
    rd_chk(8'h00, 8'h02);
    wr(8'h00, 8'h42);
    rd_chk(8'h00, 8'h42);
  endtask : t_flag
  task automatic t_fmt;
    logic [4:0] ch [4] = '{5'h03, 5'h1d, 5'h1e, 5'h07};
    logic [15:0] e;
    int n;
    for (int m = 0; m < 4; m++) begin
      wr(8'h0c, {4'h1, m[1:0], 2'h0});
      wr(8'h00, {3'h2, ch[m]});
      wait_hi(conv_irq, n);
      chk(n inside {[17:18]}, 1);
      e = fmt(m[1:0], conv_result);
      rd_chk(8'h04, e[15:8]);
      chk(conv_irq, 0);
      rd_chk(8'h08, e[7:0]);
    end
  endtask : t_fmt
  // Abort, then continuous results held by a high read and freed by the low read
  task automatic t_lock;
    logic [15:0] e;
    int n;
    wr(8'h0c, 8'h14);
    wr(8'h00, 8'h43);
    repeat (6) @(posedge hclk);
    wr(8'h00, 8'h64);
    wait_hi(conv_irq, n);
    chk(n inside {[17:18]}, 1);
    e = fmt(2'b01, conv_result);
    rd_chk(8'h04, e[15:8]);
    repeat (40) @(posedge hclk);
    rd_chk(8'h08, e[7:0]);
    wait_hi(conv_irq, n);
    chk(conv_result != e[9:0], 1);
    e = fmt(2'b01, conv_result);
    rd_chk(8'h04, e[15:8]);
    rd_chk(8'h08, e[7:0]);
    wr(8'h00, 8'h1f);
    quiet();
  endtask : t_lock
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    t_reset();
    t_clock();
    t_flag();
    t_fmt();
    t_lock();
    finish_test();
  end
endmodule : tb_top
